// ---- hw/wss_sequencer.sv ----
`timescale 1ns/1ps

module wss_sequencer
    import wss_pkg::*;
#(
    parameter int unsigned SWITCH_CYCLES = `WSS_SWITCH_CYC
) (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               run,
    input  wire logic               group_mode,
    input  wire wss_pkg::wss_link_t seq_last,
    input  wire wss_pkg::wss_grp_t  grp_last,
    input  wire logic               mem_big,
    input  wire logic               advance,
    input  wire logic               jump,
    input  wire wss_pkg::wss_grp_t  jump_index,
    input  wire logic               list_wr_en,
    input  wire wss_pkg::wss_link_t list_wr_index,
    input  wire wss_pkg::wss_addr_t list_wr_start,
    input  wire wss_pkg::wss_addr_t list_wr_len,
    input  wire wss_pkg::wss_reps_t list_wr_reps,
    input  wire logic               grp_wr_en,
    input  wire wss_pkg::wss_grp_t  grp_wr_index,
    input  wire wss_pkg::wss_link_t grp_wr_first,
    input  wire wss_pkg::wss_link_t grp_wr_last,
    input  wire logic               sample_ready,
    output logic                    sample_valid,
    output wss_pkg::wss_addr_t      sample_addr,
    output wss_pkg::wss_link_t      entry_index,
    output wss_pkg::wss_grp_t       group_index,
    output logic                    switch_late
);
    import wss_pkg::*;

    // ----------------------------------------
    // State and list storage
    // ----------------------------------------
    wss_state_t              s;          // Registered state
    wss_state_t              next_s;     // Next state
    logic [`WSS_SEQ_W-1:0]   seq_rd;     // Active sequence entry
    logic [`WSS_GRPE_W-1:0]  grp_rd;     // Selected group entry
    wss_addr_t               rd_start;   // Entry segment start
    wss_addr_t               rd_len;     // Entry segment length
    wss_reps_t               rd_reps;    // Entry repetitions
    wss_link_t               rd_first;   // Group entry first link
    wss_link_t               rd_last;    // Group entry last link

    // Sequence list: segment reference and count per entry
    wss_list_mem #(
        .W  (`WSS_SEQ_W),
        .D  (`WSS_LINK_DEPTH),
        .AW (`WSS_LINK_AW)
    ) u_seq_list (
        .clk      (clk),
        .rstn     (rstn),
        .wr_en    (list_wr_en),
        .wr_index (list_wr_index),
        .wr_data  ({list_wr_start, list_wr_len, list_wr_reps}),
        .rd_index (s.entry),
        .rd_data  (seq_rd)
    );

    // Group list: one sequence range per entry
    wss_list_mem #(
        .W  (`WSS_GRPE_W),
        .D  (`WSS_GRP_DEPTH),
        .AW (`WSS_GRP_AW)
    ) u_grp_list (
        .clk      (clk),
        .rstn     (rstn),
        .wr_en    (grp_wr_en),
        .wr_index (grp_wr_index),
        .wr_data  ({grp_wr_first, grp_wr_last}),
        .rd_index (s.grp_idx),
        .rd_data  (grp_rd)
    );

    // Entry fields
    assign {rd_start, rd_len, rd_reps} = seq_rd;
    assign {rd_first, rd_last}         = grp_rd;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Hold a link index inside the fitted limit
    function automatic wss_link_t wss_clamp(input wss_link_t v, input wss_link_t lim);
        return (v > lim) ? lim : v;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic      adv_ev;   // Advance rising edge
    logic      jmp_ev;   // Jump rising edge
    logic      switch;   // Group selection changes
    wss_link_t lim;      // Highest usable link index
    wss_link_t g_first;  // Clamped group first link
    wss_link_t g_last;   // Clamped group last link

    always_comb begin
        next_s = s;
        switch = 1'b0;

        // Pin synchronisers
        next_s.adv_s1  = advance;
        next_s.adv_s2  = s.adv_s1;
        next_s.adv_s3  = s.adv_s2;
        next_s.jmp_s1  = jump;
        next_s.jmp_s2  = s.jmp_s1;
        next_s.jmp_s3  = s.jmp_s2;
        next_s.jidx_s1 = jump_index;
        next_s.jidx_s2 = s.jidx_s1;
        next_s.big_s1  = mem_big;
        next_s.big_s2  = s.big_s1;

        // Command edges
        adv_ev = s.adv_s2 & ~s.adv_s3;
        jmp_ev = s.jmp_s2 & ~s.jmp_s3;

        // Link limit from memory option
        lim     = s.big ? `WSS_LAST_BIG : `WSS_LAST_STD;
        g_first = wss_clamp(rd_first, lim);
        g_last  = wss_clamp(rd_last, lim);

        // Switch timer
        if (s.late_busy) begin
            if (s.late_cnt >= 32'(SWITCH_CYCLES - 1)) begin
                next_s.switch_late = 1'b1;
                next_s.late_busy   = 1'b0;
            end else begin
                next_s.late_cnt = s.late_cnt + 32'h0000_0001;
            end
        end

        unique case (s.fsm)
            // Waiting for run
            WSS_IDLE: begin
                next_s.valid = 1'b0;
                next_s.big   = s.big_s2;
                if (run) begin
                    next_s.grp_mode    = group_mode;
                    next_s.switch_late = 1'b0;
                    if (group_mode) begin
                        next_s.grp_idx = '0;
                        next_s.fsm     = WSS_GSEL;
                    end else begin
                        next_s.first = '0;
                        next_s.last  = wss_clamp(seq_last, lim);
                        next_s.entry = '0;
                        next_s.fsm   = WSS_LOAD;
                    end
                end
            end
            // Fetch range of the selected sequence
            WSS_GSEL: begin
                next_s.first = g_first;
                next_s.last  = (g_last < g_first) ? g_first : g_last;
                next_s.entry = g_first;
                next_s.fsm   = WSS_LOAD;
            end
            // Fetch segment and count of the active entry
            WSS_LOAD: begin
                next_s.seg_start = rd_start;
                next_s.seg_len   = (rd_len < `WSS_SEG_MIN) ? `WSS_SEG_MIN : rd_len;
                next_s.reps      = (rd_reps == '0) ? `WSS_REPS_ONE : rd_reps;
                next_s.rep_cnt   = '0;
                next_s.offset    = '0;
                next_s.addr      = rd_start;
                next_s.valid     = 1'b1;
                next_s.fsm       = WSS_PLAY;
            end
            // Offer samples to the converter stage
            WSS_PLAY: begin
                if (sample_ready) begin
                    next_s.late_busy = 1'b0;
                    if (s.offset == s.seg_len - 20'h0_0001) begin
                        // End of one pass of the segment
                        next_s.offset = '0;
                        next_s.addr   = s.seg_start;
                        if (s.rep_cnt == s.reps - `WSS_REPS_ONE) begin
                            // Entry done, link on the next one
                            next_s.valid = 1'b0;
                            next_s.fsm   = WSS_LOAD;
                            if (s.entry >= s.last) begin
                                next_s.entry = s.first;
                            end else begin
                                next_s.entry = s.entry + 11'h001;
                            end
                        end else begin
                            next_s.rep_cnt = s.rep_cnt + `WSS_REPS_ONE;
                        end
                    end else begin
                        next_s.offset = s.offset + 20'h0_0001;
                        next_s.addr   = s.addr + 20'h0_0001;
                    end
                end
            end
        endcase

        // Group commands, jump taking priority
        if (s.fsm != WSS_IDLE && s.grp_mode) begin
            if (jmp_ev && s.jidx_s2 <= grp_last) begin
                next_s.grp_idx = s.jidx_s2;
                switch         = 1'b1;
            end else if (adv_ev) begin
                switch = 1'b1;
                if (s.grp_idx >= grp_last) begin
                    next_s.grp_idx = '0;
                end else begin
                    next_s.grp_idx = s.grp_idx + 8'h01;
                end
            end
        end

        // Drop current offer and start the new sequence
        if (switch) begin
            next_s.valid     = 1'b0;
            next_s.fsm       = WSS_GSEL;
            next_s.late_busy = 1'b1;
            next_s.late_cnt  = '0;
        end

        // Stop returns to idle
        if (!run) begin
            next_s.fsm       = WSS_IDLE;
            next_s.valid     = 1'b0;
            next_s.late_busy = 1'b0;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state
    assign sample_valid = s.valid;
    assign sample_addr  = s.addr;
    assign entry_index  = s.entry;
    assign group_index  = s.grp_idx;
    assign switch_late  = s.switch_late;
endmodule

// ---- hw/wss_defs.svh ----
`ifndef WSS_DEFS_SVH
`define WSS_DEFS_SVH

// ----------------------------------------
// Field widths
// ----------------------------------------
`define WSS_LINK_AW     11
`define WSS_LINK_DEPTH  2048
`define WSS_GRP_AW      8
`define WSS_GRP_DEPTH   256
`define WSS_SAMP_AW     20
`define WSS_REPS_W      8
`define WSS_SEQ_W       48
`define WSS_GRPE_W      22

// ----------------------------------------
// Limits and fixed values
// ----------------------------------------
`define WSS_LAST_STD    11'h1ff
`define WSS_LAST_BIG    11'h7ff
`define WSS_REPS_MAX    8'hff
`define WSS_REPS_ONE    8'h01
`define WSS_SEG_MIN     20'h0_0040

// ----------------------------------------
// Timing
// ----------------------------------------
`define WSS_CLK_NS      32'h0000_0014
`define WSS_SWITCH_NS   32'h004c_4b40
`define WSS_SWITCH_CYC  (`WSS_SWITCH_NS / `WSS_CLK_NS)

`endif

// ---- hw/wss_pkg.sv ----
package wss_pkg;
    `include "wss_defs.svh"

    // ----------------------------------------
    // Scalar types
    // ----------------------------------------
    typedef logic [`WSS_LINK_AW-1:0] wss_link_t;   // Sequence list index
    typedef logic [`WSS_GRP_AW-1:0]  wss_grp_t;    // Group list index
    typedef logic [`WSS_SAMP_AW-1:0] wss_addr_t;   // Sample memory address
    typedef logic [`WSS_REPS_W-1:0]  wss_reps_t;   // Repetition count

    // Sequencer states
    typedef enum logic [1:0] {
        WSS_IDLE,
        WSS_GSEL,
        WSS_LOAD,
        WSS_PLAY
    } wss_fsm_t;

    // ----------------------------------------
    // Whole sequencer state
    // ----------------------------------------
    typedef struct packed {
        logic              adv_s1;      // Advance pin, first stage
        logic              adv_s2;      // Advance pin, second stage
        logic              adv_s3;      // Advance, previous level
        logic              jmp_s1;      // Jump pin, first stage
        logic              jmp_s2;      // Jump pin, second stage
        logic              jmp_s3;      // Jump, previous level
        wss_grp_t          jidx_s1;     // Jump index, first stage
        wss_grp_t          jidx_s2;     // Jump index, second stage
        logic              big_s1;      // Memory option, first stage
        logic              big_s2;      // Memory option, second stage
        logic              big;         // Enlarged memory in use
        wss_fsm_t          fsm;         // Sequencer state
        logic              grp_mode;    // Group mode latched at start
        wss_grp_t          grp_idx;     // Selected group entry
        wss_link_t         first;       // First entry of sequence
        wss_link_t         last;        // Last entry of sequence
        wss_link_t         entry;       // Active entry
        wss_addr_t         seg_start;   // Segment start address
        wss_addr_t         seg_len;     // Segment length
        wss_reps_t         reps;        // Repetitions of entry
        wss_reps_t         rep_cnt;     // Completed repetitions
        wss_addr_t         offset;      // Sample within segment
        wss_addr_t         addr;        // Offered sample address
        logic              valid;       // Sample offered
        logic              late_busy;   // Switch timer running
        logic [31:0]       late_cnt;    // Switch timer
        logic              switch_late; // Switch overran its limit
    } wss_state_t;
endpackage

// ---- hw/wss_list_mem.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Flip-flop list storage, one write port,
// one combinational read port
// ----------------------------------------
module wss_list_mem #(
    parameter int W  = 8,
    parameter int D  = 16,
    parameter int AW = 4
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_index,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic [AW-1:0] rd_index,
    output logic      [W-1:0]  rd_data
);
    logic [W-1:0] mem      [D];  // Stored entries, one word each
    logic [W-1:0] next_mem [D];  // Entries after write

    // Per entry write select
    genvar i;
    generate
        for (i = 0; i < D; i++) begin : g_entry
            assign next_mem[i] = (wr_en && wr_index == AW'(i)) ? wr_data : mem[i];
        end
    endgenerate

    // Read by index
    assign rd_data = mem[rd_index];

    // Storage registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // Clear every entry
            for (int k = 0; k < D; k++) begin
                mem[k] <= '0;
            end
        end else begin
            mem <= next_mem;
        end
    end
endmodule

// ---- tb/wss_seq_sva.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the sequencer
// ----------------------------------------
module wss_seq_sva
    import wss_pkg::*;
#(
    parameter int unsigned SWITCH_CYCLES = 16
) (
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic               run,
    input wire logic               mem_big,
    input wire wss_pkg::wss_grp_t  grp_last,
    input wire logic               sample_ready,
    input wire logic               sample_valid,
    input wire wss_pkg::wss_addr_t sample_addr,
    input wire wss_pkg::wss_link_t entry_index,
    input wire wss_pkg::wss_grp_t  group_index,
    input wire logic               switch_late
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic [2:0] big_hist;  // Recent memory option samples
    logic       std_run;   // Run started on standard memory

    // Memory option history, judged while stopped
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            big_hist <= 3'h7;
            std_run  <= 1'b0;
        end else begin
            big_hist <= {big_hist[1:0], mem_big};
            if (!run) begin
                std_run <= !mem_big && (big_hist == 3'h0);
            end
        end
    end

    // Stalled sample stands or is withdrawn
    addr_hold_a: assert property (
        sample_valid && !sample_ready |=> !sample_valid || $stable(sample_addr))
        else $error("offered address moved while stalled");
    idle_a: assert property (!run |=> !sample_valid)
        else $error("sample offered while stopped");
    valid_rise_a: assert property ($rose(sample_valid) |-> $past(run))
        else $error("sample offered without run");
    entry_gap_a: assert property ($changed(entry_index) |-> !sample_valid)
        else $error("no gap at entry change");
    // Standard memory keeps the link index low
    entry_limit_a: assert property (
        std_run && run ##1 run ##1 run |-> entry_index <= 11'h1ff)
        else $error("entry index past standard limit");
    grp_range_a: assert property (run |-> group_index <= grp_last)
        else $error("group index past last entry");
    switch_drop_a: assert property ($changed(group_index) |-> !sample_valid)
        else $error("old sample kept after switch");
    // New sequence offered promptly
    switch_time_a: assert property (
        $changed(group_index) && run |-> ##[1:6] (sample_valid || !run))
        else $error("switch too slow");
    late_sticky_a: assert property (
        switch_late && run && $past(run) |=> switch_late)
        else $error("late flag dropped while running");

    // Main scenarios seen
    took_c: cover property (sample_valid && sample_ready);
    switch_c: cover property ($changed(group_index) && run);
    late_c: cover property ($rose(switch_late));
endmodule

bind wss_sequencer wss_seq_sva #(.SWITCH_CYCLES(SWITCH_CYCLES)) sva_u (.*);

// ---- tb/wss_sink.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Converter stage taking offered samples
// ----------------------------------------
module wss_sink (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [1:0] pace,
    output logic            sample_ready
);
    logic tick; // Alternating stall phase

    // Phase flips each cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick <= 1'b0;
        end else begin
            tick <= ~tick;
        end
    end
    // Pace 0 prompt, 1 every other cycle, 2 stalled
    assign sample_ready = (pace == 2'h0) || (pace == 2'h1 && tick);
endmodule

// ---- tb/tb_waveform_segment_sequencer.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Bench for the segment sequencer
// ----------------------------------------
module tb_waveform_segment_sequencer;
    import wss_pkg::*;
    logic       clk, rstn, run, group_mode, mem_big, advance, jump, list_wr_en;
    logic       grp_wr_en, sample_ready, sample_valid, switch_late;
    logic [1:0] pace;
    wss_link_t  seq_last, list_wr_index, grp_wr_first, grp_wr_last, entry_index;
    wss_grp_t   grp_last, jump_index, grp_wr_index, group_index;
    wss_addr_t  list_wr_start, list_wr_len, sample_addr;
    wss_reps_t  list_wr_reps;
    int         error_cnt, compares, cyc;

    wss_sequencer #(.SWITCH_CYCLES(16)) dut_u (.*);
    wss_sink sink_u (.clk(clk), .rstn(rstn), .pace(pace), .sample_ready(sample_ready));

    // Free running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt++;
            $display("[FAIL] %0t timeout", $time);
            report_and_stop();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task report_and_stop();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // List entry write, strobe left high
    task automatic put(input wss_link_t i, input wss_addr_t s, input wss_addr_t l,
                       input wss_reps_t r);
        list_wr_en    <= 1'b1;
        list_wr_index <= i;
        list_wr_start <= s;
        list_wr_len   <= l;
        list_wr_reps  <= r;
        @(posedge clk);
    endtask

    // Group entry holding one link
    task automatic gput(input wss_grp_t i, input wss_link_t k);
        grp_wr_en    <= 1'b1;
        grp_wr_index <= i;
        grp_wr_first <= k;
        grp_wr_last  <= k;
        @(posedge clk);
    endtask

    // Next accepted sample, bounded
    task automatic take(output wss_addr_t a, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(sample_valid === 1'b1 && sample_ready === 1'b1) && n < 300);
        a = sample_addr;
    endtask

    // Command pin pulse, three cycles high
    task automatic pin(input logic j, input wss_grp_t idx);
        @(posedge clk);
        advance    <= ~j;
        jump       <= j;
        jump_index <= idx;
        repeat (3) @(posedge clk);
        advance <= 1'b0;
        jump    <= 1'b0;
    endtask

    // Command, then new sequence start expected
    task automatic cmd(input logic j, input wss_grp_t idx, input wss_grp_t g,
                       input wss_addr_t s);
        wss_addr_t a;
        int        n, t;
        pin(j, idx);
        t = 3;
        do begin
            take(a, n);
            t += n;
        end while (a !== s && t < 60);
        chk(group_index === g, "wrong group selected");
        chk(a === s && t < 14, "new sequence late");
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_seq();
        wss_addr_t a, e;
        int        n, k;
        @(posedge clk);
        put(11'h000, 20'h0_0100, 20'h0_0040, 8'hff);
        put(11'h001, 20'h0_0400, 20'h0_000a, 8'h00);
        list_wr_en <= 1'b0;
        seq_last   <= 11'h001;
        pace       <= 2'h1;
        run        <= 1'b1;
        for (k = 0; k < 16448; k++) begin
            take(a, n);
            e = ((k >= 16320 && k < 16384) ? 20'h0_0400 : 20'h0_0100) + 20'(k % 64);
            chk(a === e, "sequence address");
            if (a !== e) break;
        end
        chk(entry_index === 11'h000, "no wrap to first entry");
        @(posedge clk);
        run <= 1'b0;
        $display("sequence test done");
    endtask

    task automatic t_group();
        wss_addr_t a;
        int        n;
        put(11'h002, 20'h0_1000, 20'h0_0040, 8'h01);
        put(11'h003, 20'h0_2000, 20'h0_0040, 8'h01);
        put(11'h004, 20'h0_3000, 20'h0_0040, 8'h01);
        list_wr_en <= 1'b0;
        gput(8'h00, 11'h002);
        gput(8'h01, 11'h003);
        gput(8'h02, 11'h004);
        gput(8'h03, 11'h600);
        grp_wr_en  <= 1'b0;
        grp_last   <= 8'h03;
        group_mode <= 1'b1;
        mem_big    <= 1'b1;
        pace       <= 2'h0;
        repeat (4) @(posedge clk);
        run <= 1'b1;
        take(a, n);
        chk(a === 20'h0_1000, "first sequence not played");
        repeat (300) @(negedge clk);
        chk(group_index === 8'h00, "first sequence left");
        cmd(1'b0, 8'h00, 8'h01, 20'h0_2000);
        cmd(1'b1, 8'h00, 8'h00, 20'h0_1000);
        pin(1'b1, 8'h05);
        repeat (10) @(negedge clk);
        chk(group_index === 8'h00, "out of range jump taken");
        cmd(1'b1, 8'h02, 8'h02, 20'h0_3000);
        cmd(1'b0, 8'h00, 8'h03, 20'h0_0000);
        chk(entry_index === 11'h600, "enlarged link index cut");
        cmd(1'b0, 8'h00, 8'h00, 20'h0_1000);
        chk(switch_late === 1'b0, "prompt switch flagged");
        $display("group test done");
    endtask

    task automatic t_late();
        @(posedge clk);
        pace <= 2'h2;
        pin(1'b0, 8'h00);
        repeat (40) @(negedge clk);
        chk(switch_late === 1'b1, "stalled switch not flagged");
        @(posedge clk);
        pace <= 2'h0;
        run  <= 1'b0;
        repeat (2) @(posedge clk);
        run <= 1'b1;
        repeat (4) @(negedge clk);
        chk(switch_late === 1'b0, "flag kept over restart");
        @(posedge clk);
        run <= 1'b0;
        $display("late test done");
    endtask

    task automatic t_limit();
        wss_addr_t a;
        int        n;
        put(11'h000, 20'h0_0100, 20'h0_0040, 8'h01);
        put(11'h1ff, 20'h0_0800, 20'h0_0040, 8'h01);
        list_wr_en <= 1'b0;
        seq_last   <= 11'h7ff;
        group_mode <= 1'b0;
        mem_big    <= 1'b0;
        repeat (4) @(posedge clk);
        run <= 1'b1;
        n = 0;
        while (entry_index !== 11'h1ff && n < 40000) begin
            @(negedge clk);
            n++;
        end
        take(a, n);
        chk(a === 20'h0_0800, "last entry segment");
        n = 0;
        while (entry_index === 11'h1ff && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(entry_index === 11'h000, "link limit not kept");
        @(posedge clk);
        run <= 1'b0;
        $display("limit test done");
    endtask

    // Main sequence
    initial begin
        {rstn, run, group_mode, mem_big, advance, jump, list_wr_en, grp_wr_en} = '0;
        {seq_last, list_wr_index, grp_wr_first, grp_wr_last} = '0;
        {grp_last, jump_index, grp_wr_index, list_wr_reps} = '0;
        {list_wr_start, list_wr_len} = '0;
        pace      = 2'h0;
        error_cnt = 0;
        compares  = 0;
        cyc       = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_seq();
        t_group();
        t_late();
        t_limit();
        report_and_stop();
    end
endmodule
